/* File: rtl/fbrs_pkg.sv */
// constants and types for the flash burst read sequencer
package fbrs_pkg;
  // ==========================================================
  // command codes
  localparam logic [7:0] CMD_CFG_SETUP = 8'h60;
  localparam logic [7:0] CMD_SET_READ_CFG = 8'h03;
  localparam logic [7:0] CMD_SET_PART_CFG = 8'h04;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLR_STATUS = 8'h50;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  // ==========================================================
  // identifier addresses
  localparam logic [15:0] ID_ADDR_READ_CFG = 16'h0005;
  localparam logic [15:0] ID_ADDR_PART_CFG = 16'h0006;
  // ==========================================================
  // read configuration fields
  localparam logic [15:0] READ_CFG_RESET = 16'hffff;
  localparam logic [15:0] PART_CFG_RESET = 16'h0100;
  localparam int BL_LSB = 0;
  localparam int BW_BIT = 3;
  localparam int BO_BIT = 7;
  localparam int WC_BIT = 8;
  localparam int FC_LSB = 11;
  localparam logic [2:0] BL_4 = 3'h1;
  localparam logic [2:0] BL_8 = 3'h2;
  localparam logic [2:0] BL_CONT = 3'h7;
  // ==========================================================
  // status bits
  localparam int STAT_ERR_LO = 4;
  localparam int STAT_ERR_HI = 5;
  localparam int STAT_READY = 7;
  localparam logic [7:0] STAT_IDLE = 8'h80;
  // ==========================================================
  // geometry
  localparam int BOUNDARY_WORDS = 64;
  localparam int ADDR_W = 16;
  // ==========================================================
  // command decoder states
  typedef enum logic [3:0] {
    MODE_ARRAY = 4'h1,
    MODE_SETUP = 4'h2,
    MODE_ID = 4'h4,
    MODE_STATUS = 4'h8
  } fbrs_mode_t;
endpackage : fbrs_pkg

/* File: rtl/fbrs_addr_gen.sv */
// burst address order generator
`timescale 1ns/10ps
module fbrs_addr_gen #(
  parameter int ADDR_W = 16
) (
  // burst setting
  input wire logic [ADDR_W-1:0] start_in,
  input wire logic [2:0] count_in,
  input wire logic [2:0] length_in,
  input wire logic wrap_n_in,
  input wire logic linear_in,
  input wire logic [ADDR_W-1:0] linear_addr_in,
  // result
  output logic [ADDR_W-1:0] addr_out
);
  // ==========================================================
  // order selection
  logic [2:0] mask;
  logic [2:0] lane;
  always_comb begin
    mask = (length_in == fbrs_pkg::BL_8) ? 3'h7 : 3'h3;
    if (linear_in) begin
      lane = start_in[2:0] + count_in;
    end else begin
      lane = start_in[2:0] ^ count_in;
    end
    if (wrap_n_in || length_in == fbrs_pkg::BL_CONT) begin
      addr_out = linear_addr_in;
    end else begin
      addr_out = (start_in & ~{{(ADDR_W-3){1'b0}}, mask}) |
                 {{(ADDR_W-3){1'b0}}, lane & mask};
    end
  end
endmodule : fbrs_addr_gen

/* File: rtl/fbrs_sequencer.sv */
// flash burst read sequencer: command decoder and burst addressing
//
// Notes on behaviour
// - length field picks 4-word, 8-word or continuous bursts.
// - continuous burst counts linearly until space end or partition edge.
// - continuous or no-wrap bursts may stall at first 64-word crossing.
// - start aligned to 64 words never stalls.
// - start on last word before boundary stalls for full latency.
// - at most one stall per burst.
// - burst not crossing a boundary never stalls.
// - delay output warns host; host holds off while it is high.
// - linear wrap bursts stay inside the aligned burst group.
// - interleaved order is start xor counter.
// - no-wrap bursts count linearly across group edge; linear only.
// - bad sequence sets status bits 4 and 5 until clear-status.
// - good configuration returns device to read-array mode.
// - identifier mode returns codes at 0005h and 0006h.
// - order bit 0 interleaved, wrap bit 0 wraps; no-wrap only linear.
// - 001 four, 010 eight, 111 continuous linear.
// - delay config bit: during stall or one cycle earlier.
// - read configuration resets to all ones.
`timescale 1ns/10ps
module fbrs_sequencer #(
  parameter int ADDR_W = fbrs_pkg::ADDR_W,
  parameter logic [ADDR_W-1:0] PART_LIMIT = '1
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // host write strobe, data and address (synchronous logic)
  input wire logic wr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [ADDR_W-1:0] addr_in,
  // register read
  input wire logic rd_in,
  output logic [15:0] rd_data_out,
  // burst control
  input wire logic burst_start_in,
  input wire logic burst_next_in,
  output logic [ADDR_W-1:0] burst_addr_out,
  output logic burst_active_out,
  output logic delay_out,
  // configuration view
  output logic [15:0] read_config_reg_out,
  output logic [15:0] partition_config_reg_out,
  output logic [7:0] status_out
);
  // ==========================================================
  // command decoder
  fbrs_pkg::fbrs_mode_t mode_q;
  logic [15:0] read_config_reg_q;
  logic [15:0] partition_config_reg_q;
  logic [ADDR_W-1:0] cfg_code_q;
  logic seq_err_q;
  logic [15:0] rd_data_q;
  logic [7:0] status_w;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_q <= fbrs_pkg::MODE_ARRAY;
      read_config_reg_q <= fbrs_pkg::READ_CFG_RESET;
      partition_config_reg_q <= fbrs_pkg::PART_CFG_RESET;
      cfg_code_q <= '0;
      seq_err_q <= 1'b0;
    end else if (wr_in) begin
      case (mode_q)
        fbrs_pkg::MODE_SETUP: begin
          mode_q <= fbrs_pkg::MODE_ARRAY;
          if (wr_data_in == fbrs_pkg::CMD_SET_READ_CFG) begin
            read_config_reg_q <= cfg_code_q[15:0];
          end else if (wr_data_in == fbrs_pkg::CMD_SET_PART_CFG) begin
            partition_config_reg_q <= cfg_code_q[15:0];
          end else begin
            seq_err_q <= 1'b1;
            mode_q <= fbrs_pkg::MODE_STATUS;
          end
        end
        default: begin
          case (wr_data_in)
            fbrs_pkg::CMD_CFG_SETUP: begin
              mode_q <= fbrs_pkg::MODE_SETUP;
              cfg_code_q <= addr_in;
            end
            fbrs_pkg::CMD_READ_ID: mode_q <= fbrs_pkg::MODE_ID;
            fbrs_pkg::CMD_READ_STATUS: mode_q <= fbrs_pkg::MODE_STATUS;
            fbrs_pkg::CMD_CLR_STATUS: seq_err_q <= 1'b0;
            default: mode_q <= fbrs_pkg::MODE_ARRAY;
          endcase
        end
      endcase
    end
  end
  // ==========================================================
  // register read path
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_q <= '0;
    end else if (rd_in) begin
      case (mode_q)
        fbrs_pkg::MODE_ID: begin
          if (addr_in[15:0] == fbrs_pkg::ID_ADDR_READ_CFG) begin
            rd_data_q <= read_config_reg_q;
          end else if (addr_in[15:0] == fbrs_pkg::ID_ADDR_PART_CFG) begin
            rd_data_q <= partition_config_reg_q;
          end else begin
            rd_data_q <= '0;
          end
        end
        fbrs_pkg::MODE_STATUS: rd_data_q <= {8'h00, status_w};
        default: rd_data_q <= '0;
      endcase
    end
  end
  always_comb begin
    status_w = fbrs_pkg::STAT_IDLE;
    status_w[fbrs_pkg::STAT_ERR_LO] = seq_err_q;
    status_w[fbrs_pkg::STAT_ERR_HI] = seq_err_q;
  end
  // ==========================================================
  // configuration decode
  logic [2:0] blen;
  logic no_wrap;
  logic lin;
  logic early_wait;
  logic [2:0] latency;
  always_comb begin
    blen = read_config_reg_q[fbrs_pkg::BL_LSB +: 3];
    // no-wrap with interleaved order is forced linear below
    no_wrap = read_config_reg_q[fbrs_pkg::BW_BIT];
    lin = read_config_reg_q[fbrs_pkg::BO_BIT] | read_config_reg_q[fbrs_pkg::BW_BIT] |
          (blen == fbrs_pkg::BL_CONT);
    early_wait = read_config_reg_q[fbrs_pkg::WC_BIT];
    latency = read_config_reg_q[fbrs_pkg::FC_LSB +: 3];
  end
  // ==========================================================
  // burst engine
  logic [ADDR_W-1:0] start_q;
  logic [ADDR_W-1:0] lin_addr_q;
  logic [2:0] count_q;
  logic [2:0] stall_q;
  logic stalled_q;
  logic active_q;
  logic delay_q;
  logic [ADDR_W-1:0] gen_addr;
  logic [ADDR_W-1:0] addr_q;
  logic stall_mode;
  logic at_edge;
  logic [2:0] last_cnt;
  always_comb begin
    stall_mode = no_wrap | (blen == fbrs_pkg::BL_CONT);
    at_edge = (lin_addr_q[5:0] == 6'h3f);
    last_cnt = (blen == fbrs_pkg::BL_8) ? 3'h7 : 3'h3;
  end
  fbrs_addr_gen #(.ADDR_W(ADDR_W)) u_gen (
    .start_in(start_q),
    .count_in(count_q),
    .length_in(blen),
    .wrap_n_in(no_wrap),
    .linear_in(lin),
    .linear_addr_in(lin_addr_q),
    .addr_out(gen_addr)
  );
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      start_q <= '0;
      lin_addr_q <= '0;
      count_q <= '0;
      stall_q <= '0;
      stalled_q <= 1'b0;
      active_q <= 1'b0;
    end else if (burst_start_in) begin
      start_q <= addr_in;
      lin_addr_q <= addr_in;
      count_q <= '0;
      stall_q <= '0;
      // an aligned start never stalls, so its single stall counts as used
      stalled_q <= (addr_in[5:0] == 6'h00);
      active_q <= (mode_q == fbrs_pkg::MODE_ARRAY);
    end else if (active_q && stall_q != 3'h0) begin
      stall_q <= stall_q - 3'h1;
    end else if (active_q && burst_next_in) begin
      if (stall_mode && at_edge && !stalled_q) begin
        stall_q <= latency;
        stalled_q <= 1'b1;
      end
      lin_addr_q <= lin_addr_q + 1'b1;
      count_q <= count_q + 3'h1;
      if (blen == fbrs_pkg::BL_CONT) begin
        if (lin_addr_q == PART_LIMIT) active_q <= 1'b0;
      end else if (count_q == last_cnt) begin
        active_q <= 1'b0;
      end
    end
  end
  // ==========================================================
  // outputs and delay indicator
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      delay_q <= 1'b0;
      addr_q <= '0;
    end else begin
      addr_q <= gen_addr;
      // early mode warns while the last word before the boundary is out
      if (early_wait) begin
        delay_q <= active_q && ((stall_q > 3'h1) ||
                   (burst_next_in && stall_mode && at_edge && !stalled_q));
      end else begin
        delay_q <= active_q && (stall_q != 3'h0);
      end
    end
  end
  assign burst_addr_out = addr_q;
  assign delay_out = delay_q;
  assign burst_active_out = active_q;
  assign rd_data_out = rd_data_q;
  assign read_config_reg_out = read_config_reg_q;
  assign partition_config_reg_out = partition_config_reg_q;
  assign status_out = status_w;
  // ==========================================================
  // checks
  stall_once_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    stalled_q && !burst_start_in |=> stalled_q) else $error("second stall");
  no_stall_aligned_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    burst_start_in && addr_in[5:0] == 6'h00 |=> stalled_q && stall_q == 3'h0)
    else $error("aligned stall");
  err_sticky_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    seq_err_q && !(wr_in && wr_data_in == fbrs_pkg::CMD_CLR_STATUS) |=> seq_err_q)
    else $error("error lost");
  cfg_back_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    wr_in && mode_q == fbrs_pkg::MODE_SETUP && wr_data_in == fbrs_pkg::CMD_SET_READ_CFG
    |=> mode_q == fbrs_pkg::MODE_ARRAY) else $error("not array mode");
  cfg_load_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    wr_in && mode_q == fbrs_pkg::MODE_SETUP && wr_data_in == fbrs_pkg::CMD_SET_READ_CFG
    |=> read_config_reg_q == $past(cfg_code_q)) else $error("config not loaded");
  stall_len_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $past(stall_q) == 3'h0 && stall_q != 3'h0 |-> stall_q == latency)
    else $error("stall length");
  no_stall_mode_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !stall_mode |-> stall_q == 3'h0 || !active_q) else $error("wrap stall");
  wrap_group_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    active_q && !stall_mode |-> gen_addr[ADDR_W-1:3] == start_q[ADDR_W-1:3])
    else $error("left group");
  cover_stall_c: cover property (@(posedge ref_clk_in) $rose(stalled_q));
  cover_err_c: cover property (@(posedge ref_clk_in) $rose(seq_err_q));
  cover_end_c: cover property (@(posedge ref_clk_in) $fell(active_q));
endmodule : fbrs_sequencer

/* File: tb/fbrs_host_model.sv */
// host side model: fetches burst words and holds off during stalls
`timescale 1ns/10ps
module fbrs_host_model (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // bench control and device stall flag
  input wire logic fetch_in,
  input wire logic delay_in,
  // word request to the device
  output logic next_out
);
  // ==========================================================
  // word fetch
  // registered so the request only moves just after an edge, like a real host
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      next_out <= 1'b0;
    end else begin
      next_out <= #1 fetch_in & ~delay_in;
    end
  end
endmodule : fbrs_host_model

/* File: tb/tb_top.sv */
// self-checking bench for the burst read sequencer
`timescale 1ns/10ps
module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic start = 1'b0;
  logic fetch = 1'b0;
  logic nxt;
  logic [7:0] wdat = 8'h00;
  logic [15:0] addr = 16'h0000;
  logic [15:0] rdat, baddr, rcfg, pcfg;
  logic [7:0] stat;
  logic act, dly;
  int errors = 0;
  int cmp_count = 0;
  int d;
  always #5 ref_clk = ~ref_clk;
  fbrs_sequencer dut (.ref_clk_in(ref_clk), .rst_in(rst), .wr_in(wr), .wr_data_in(wdat),
    .addr_in(addr), .rd_in(rd), .rd_data_out(rdat), .burst_start_in(start),
    .burst_next_in(nxt), .burst_addr_out(baddr), .burst_active_out(act), .delay_out(dly),
    .read_config_reg_out(rcfg), .partition_config_reg_out(pcfg), .status_out(stat));
  fbrs_host_model host (.ref_clk_in(ref_clk), .rst_in(rst), .fetch_in(fetch),
    .delay_in(dly), .next_out(nxt));
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr_cmd(input logic [7:0] c, input logic [15:0] a);
    @(posedge ref_clk) #1 wr = 1'b1;
    wdat = c;
    addr = a;
    @(posedge ref_clk) #1 wr = 1'b0;
  endtask : wr_cmd
  task automatic rd_reg(input logic [15:0] a);
    @(posedge ref_clk) #1 rd = 1'b1;
    addr = a;
    @(posedge ref_clk) #1 rd = 1'b0;
  endtask : rd_reg
  task automatic begin_burst(input logic [15:0] a);
    @(posedge ref_clk) #1 start = 1'b1;
    addr = a;
    @(posedge ref_clk) #1 start = 1'b0;
  endtask : begin_burst
  // continuous fetch; addresses must step by one, stall cycles counted
  task automatic run(input logic [15:0] a, input int n, output int dc);
    logic [15:0] prev;
    dc = 0;
    begin_burst(a);
    prev = a - 16'h0001;
    fetch = 1'b1;
    repeat (n) begin
      @(posedge ref_clk) #1;
      if (dly === 1'b1) dc++;
      if (baddr !== prev) chk(baddr, prev + 16'h0001);
      prev = baddr;
    end
    fetch = 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask : run
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  // ==========================================================
  // wrap and order table: config code, start offset, length
  logic [15:0] codes [4] = '{16'h1081, 16'h1082, 16'h1002, 16'h1089};
  int starts [4] = '{1, 3, 5, 3};
  int lens [4] = '{4, 8, 8, 4};
  function automatic logic [15:0] expect_addr(input logic [15:0] c, input int s, input int i,
      input int n);
    if (c[3]) return 16'h0100 + 16'(s + i);
    if (!c[7]) return 16'h0100 + 16'(s ^ i);
    return 16'h0100 + 16'((s + i) % n);
  endfunction : expect_addr
  initial begin
    repeat (6) @(posedge ref_clk);
    #1 rst = 1'b0;
    chk(rcfg, 16'hffff);
    chk({8'h00, stat}, 16'h0080);
    wr_cmd(8'h60, 16'h0500);
    wr_cmd(8'h04, 16'h0500);
    chk(pcfg, 16'h0500);
    for (int k = 0; k < 4; k++) begin
      wr_cmd(8'h60, codes[k]);
      wr_cmd(8'h03, codes[k]);
      chk(rcfg, codes[k]);
      begin_burst(16'h0100 + 16'(starts[k]));
      chk({15'h0000, act}, 16'h0001);
      @(posedge ref_clk) #1;
      chk(baddr, expect_addr(codes[k], starts[k], 0, lens[k]));
      for (int i = 1; i < lens[k]; i++) begin
        @(posedge ref_clk) #1 fetch = 1'b1;
        @(posedge ref_clk) #1 fetch = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        chk(baddr, expect_addr(codes[k], starts[k], i, lens[k]));
      end
    end
    run(16'h0200, 12, d);
    chk(16'(d), 16'h0000);
    wr_cmd(8'h60, 16'h108f);
    wr_cmd(8'h03, 16'h108f);
    run(16'h003f, 20, d);
    chk(16'(d), 16'h0002);
    run(16'h0040, 20, d);
    chk(16'(d), 16'h0000);
    run(16'h0030, 160, d);
    chk(16'(d), 16'h0002);
    wr_cmd(8'h90, 16'h0000);
    rd_reg(16'h0005);
    chk(rdat, 16'h108f);
    rd_reg(16'h0006);
    chk(rdat, 16'h0500);
    wr_cmd(8'hff, 16'h0000);
    wr_cmd(8'h60, 16'h1081);
    wr_cmd(8'h11, 16'h1081);
    chk({8'h00, stat & 8'h30}, 16'h0030);
    wr_cmd(8'h70, 16'h0000);
    rd_reg(16'h0000);
    chk(rdat, 16'h00b0);
    wr_cmd(8'hff, 16'h0000);
    chk({8'h00, stat & 8'h30}, 16'h0030);
    wr_cmd(8'h50, 16'h0000);
    chk({8'h00, stat}, 16'h0080);
    chk(rcfg, 16'h108f);
    wr_cmd(8'h60, 16'h118f);
    wr_cmd(8'h03, 16'h118f);
    run(16'h003f, 20, d);
    chk(16'(d), 16'h0002);
    complete_run();
  end
  // ==========================================================
  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #100us;
    errors++;
    complete_run();
  end
endmodule : tb_top
